// ### include/rap_map.svh
// Constants for the reset and alarm pin block
`ifndef RAP_MAP_SVH
`define RAP_MAP_SVH
`define RAP_CHANNELS 4
`define RAP_MON_OFF 2'h0
`define RAP_MON_RSVD 2'h1
`define RAP_MON_SLOW 2'h2
`define RAP_MON_NORMAL 2'h3
`define RAP_MON_RESET 2'h3
`define RAP_ENABLE_RESET 1'h0
`define RAP_POL_RESET 1'h0
`define RAP_FAULT_POL_RESET 1'h0
`define RAP_MASK_RESET 1'h0
`define RAP_SLOW_NEED_NS 320
`define RAP_CLK_NS 40
`define RAP_SLOW_CYCLES ((`RAP_SLOW_NEED_NS + `RAP_CLK_NS - 1) / `RAP_CLK_NS)
`endif

// ### include/rap_pkg.sv
// Types for the reset and alarm pin block
package rap_pkg;
  typedef logic [1:0] rap_mon_t;
  typedef struct packed {
    logic alarmPinEnable;
    logic alarmPinPolarity;
    logic inputFaultPolarity;
    logic alarmMask;
    rap_mon_t signalMonitorSelect;
  } rap_cfg_s;
endpackage

// ### src/rap_sync2.sv
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module rap_sync2 (
  // Clock
  input wire logic clk,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic stage1Reg;
  logic stage2Reg;
  always_ff @(posedge clk) begin
    stage1Reg <= din;
    stage2Reg <= stage1Reg;
  end
  assign dout = stage2Reg;
endmodule

// ### src/rap_reset_alarm.sv
// Reset collection and input-fault alarm pin logic, one instance for all channels (alarm watches channel 0 only)
`timescale 1ns/1ps
`include "rap_map.svh"
module rap_reset_alarm #(
  parameter int CHANNELS = `RAP_CHANNELS,
  parameter int SLOW_CYCLES = `RAP_SLOW_CYCLES
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic reset,
  // External reset pins, one per channel
  input wire logic [CHANNELS-1:0] hwResetPins_n,
  // Host configuration, loaded when cfgLoad is high
  input wire logic cfgLoad,
  input wire rap_pkg::rap_cfg_s cfgIn,
  // Raw input-clock missing detector per channel
  input wire logic [CHANNELS-1:0] inputSignalMissing,
  // Reset state and output clock gating
  output logic internalReset,
  output logic clockOutEnable,
  // Alarm pin, three signals
  output logic alarmPinOut,
  output logic alarmPinOe,
  output logic alarmActive
);
  logic [CHANNELS-1:0] pinSync;
  logic anyPinLow;
  logic resetReg;
  logic resetNext;
  rap_pkg::rap_cfg_s cfgReg;
  rap_pkg::rap_cfg_s cfgNext;
  logic programmedReg;
  logic programmedNext;
  logic [3:0] slowCountReg;
  logic [3:0] slowCountNext;
  logic faultReg;
  logic faultNext;
  logic slowFault;
  logic monFault;
  logic outReg;
  logic oeReg;
  logic clkOeReg;
  logic outNext;
  logic oeNext;
  logic clkOeNext;
  logic faultLevel;
  logic activeReg;
  logic activeNext;
  logic lossSync;
  rap_pkg::rap_cfg_s cfgDefault;

  // Pins are asynchronous, two flops each before use
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gSync
      rap_sync2 uSync (.clk(clk), .din(hwResetPins_n[g]), .dout(pinSync[g]));
    end
  endgenerate

  // Loss flag comes from the input clock's domain, so it is resynchronised too
  rap_sync2 uLossSync (.clk(clk), .din(inputSignalMissing[0]), .dout(lossSync));

  assign anyPinLow = ~&pinSync;
  assign resetNext = reset | anyPinLow;

  always_ff @(posedge clk) begin
    resetReg <= resetNext;
  end

  // Configuration defaults whenever reset is held
  assign cfgDefault = rap_pkg::rap_cfg_s'{`RAP_ENABLE_RESET, `RAP_POL_RESET, `RAP_FAULT_POL_RESET,
                                          `RAP_MASK_RESET, `RAP_MON_RESET};
  assign cfgNext = resetReg ? cfgDefault : (cfgLoad ? cfgIn : cfgReg);
  assign programmedNext = resetReg ? 1'b0 : (programmedReg | cfgLoad);

  always_ff @(posedge clk) begin
    cfgReg <= cfgNext;
    programmedReg <= programmedNext;
  end

  // Slow detector: loss must persist before it counts, less sensitive
  assign slowCountNext = (resetReg | ~lossSync) ? 4'h0 :
                         (slowCountReg == 4'(SLOW_CYCLES)) ? slowCountReg :
                         slowCountReg + 4'h1;
  assign slowFault = (slowCountReg == 4'(SLOW_CYCLES));
  assign monFault = (cfgReg.signalMonitorSelect == `RAP_MON_NORMAL) ? lossSync :
                    (cfgReg.signalMonitorSelect == `RAP_MON_SLOW) ? slowFault :
                    1'b0;
  assign faultNext = resetReg ? 1'b0 : monFault;

  always_ff @(posedge clk) begin
    slowCountReg <= slowCountNext;
    faultReg <= faultNext;
  end

  // Mask gates the event; polarity bits set the asserted level
  assign activeNext = ~resetReg & faultReg & ~cfgReg.alarmMask;
  assign faultLevel = activeNext ^ cfgReg.inputFaultPolarity ^ cfgReg.alarmPinPolarity;
  assign outNext = ~resetReg & cfgReg.alarmPinEnable & faultLevel;
  assign oeNext = ~resetReg & cfgReg.alarmPinEnable;
  assign clkOeNext = ~resetReg & programmedReg;

  always_ff @(posedge clk) begin
    outReg <= outNext;
    oeReg <= oeNext;
    clkOeReg <= clkOeNext;
    activeReg <= activeNext;
  end

  assign internalReset = resetReg;
  assign clockOutEnable = clkOeReg;
  assign alarmPinOut = outReg;
  assign alarmPinOe = oeReg;
  assign alarmActive = activeReg;

  property p_clk_off_in_reset;
    @(posedge clk) resetReg |=> !clockOutEnable;
  endproperty
  a_clk_off_in_reset: assert property (p_clk_off_in_reset) else $error("clock out on in reset");

  property p_pin_resets_all;
    @(posedge clk) disable iff (reset) $fell(hwResetPins_n[0]) |-> ##[2:3] internalReset;
  endproperty
  a_pin_resets_all: assert property (p_pin_resets_all) else $error("pin reset missed");

  property p_cfg_default;
    @(posedge clk) resetReg |=> (cfgReg.alarmPinEnable == `RAP_ENABLE_RESET);
  endproperty
  a_cfg_default: assert property (p_cfg_default) else $error("config not defaulted");

  property p_need_program;
    @(posedge clk) disable iff (reset) (!programmedReg) |=> !clockOutEnable;
  endproperty
  a_need_program: assert property (p_need_program) else $error("clock out unprogrammed");

  property p_float_disabled;
    @(posedge clk) disable iff (reset) (!cfgReg.alarmPinEnable) |=> !alarmPinOe;
  endproperty
  a_float_disabled: assert property (p_float_disabled) else $error("pin driven disabled");

  property p_enable_drives;
    @(posedge clk) disable iff (reset) (cfgReg.alarmPinEnable && !resetReg) |=> alarmPinOe;
  endproperty
  a_enable_drives: assert property (p_enable_drives) else $error("pin not driven");

  property p_mask;
    @(posedge clk) disable iff (reset) cfgReg.alarmMask |=> !alarmActive;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alarm seen");

  property p_level;
    @(posedge clk) disable iff (reset) alarmPinOe |-> alarmPinOut ==
      (alarmActive ^ $past(cfgReg.inputFaultPolarity) ^ $past(cfgReg.alarmPinPolarity));
  endproperty
  a_level: assert property (p_level) else $error("alarm level wrong");

  property p_mon_off;
    @(posedge clk) disable iff (reset)
      (cfgReg.signalMonitorSelect == `RAP_MON_OFF) |=> !faultReg;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("fault with monitor off");

  property p_sync_release;
    @(posedge clk) disable iff (reset)
      $fell(internalReset) |-> (!clockOutEnable && !alarmPinOe && !alarmActive);
  endproperty
  a_sync_release: assert property (p_sync_release) else $error("release unsynced");

  // Any held-low pin reaches the common reset after the synchroniser delay
  property p_any_pin;
    @(posedge clk) disable iff (reset) !(&hwResetPins_n) |-> ##3 internalReset;
  endproperty
  a_any_pin: assert property (p_any_pin) else $error("channel pin reset missed");

  property p_cfg_all_default;
    @(posedge clk) resetReg |=> ((cfgReg.signalMonitorSelect == `RAP_MON_RESET) &&
      (cfgReg.alarmMask == `RAP_MASK_RESET) && (cfgReg.alarmPinPolarity == `RAP_POL_RESET));
  endproperty
  a_cfg_all_default: assert property (p_cfg_all_default) else $error("config fields kept");

  property p_out_low_disabled;
    @(posedge clk) disable iff (reset) (!cfgReg.alarmPinEnable) |=> !alarmPinOut;
  endproperty
  a_out_low_disabled: assert property (p_out_low_disabled) else $error("pin value disabled");

  property p_mon_rsvd;
    @(posedge clk) disable iff (reset)
      (cfgReg.signalMonitorSelect == `RAP_MON_RSVD) |=> !faultReg;
  endproperty
  a_mon_rsvd: assert property (p_mon_rsvd) else $error("fault with reserved monitor");

  // Held loss with normal monitoring must reach the alarm
  property p_loss_reported;
    @(posedge clk) disable iff (reset)
      (!internalReset && (cfgReg.signalMonitorSelect == `RAP_MON_NORMAL) && !cfgReg.alarmMask &&
       inputSignalMissing[0])[*5] |=> alarmActive;
  endproperty
  a_loss_reported: assert property (p_loss_reported) else $error("loss not reported");

  property p_no_loss;
    @(posedge clk) disable iff (reset) (!inputSignalMissing[0])[*5] |=> !alarmActive;
  endproperty
  a_no_loss: assert property (p_no_loss) else $error("alarm with input present");

  // Holds for slow counts of two or more: a short loss never trips it
  property p_slow_hold;
    @(posedge clk) disable iff (reset)
      ($rose(faultReg) && ($past(cfgReg.signalMonitorSelect) == `RAP_MON_SLOW)) |->
      ($past(inputSignalMissing[0], 4) && $past(inputSignalMissing[0], 5));
  endproperty
  a_slow_hold: assert property (p_slow_hold) else $error("slow detector too quick");

  // Main scenarios
  c_alarm: cover property (@(posedge clk) alarmActive);
  c_slow: cover property (@(posedge clk) slowFault);
  c_clk_on: cover property (@(posedge clk) clockOutEnable);
  c_pin_release: cover property (@(posedge clk) $fell(internalReset));
endmodule

// ### tb/rap_host_model.sv
// Host side of the alarm pin: resolves the pin level it sees
`timescale 1ns/1ps
module rap_host_model (
  // Clock
  input wire logic clk,
  // Pin from the device
  input wire logic alarmPinOut,
  input wire logic alarmPinOe,
  // Level seen by the host
  output logic alarmWire
);
  logic lastReg;
  // Remembers only what the device last drove
  always_ff @(posedge clk) begin
    if (alarmPinOe) begin
      lastReg <= alarmPinOut;
    end
  end
  // No pull on this pin, so a released pin shows the inverse of its last level
  assign alarmWire = alarmPinOe ? alarmPinOut : ~lastReg;
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the reset and alarm pin block
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [3:0] pins_n = 4'hF;
  logic cfgLoad = 1'h0;
  rap_pkg::rap_cfg_s cfgIn = '0;
  logic [3:0] miss = 4'h0;
  logic intRst, clkEn, pinOut, pinOe, active, pinWire;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // Short slow-detector hold keeps the run brief; the tests assume two or more
  localparam int SLOW = 2;
  rap_reset_alarm #(.SLOW_CYCLES(SLOW)) u_dut (.clk(clk), .reset(reset), .hwResetPins_n(pins_n),
    .cfgLoad(cfgLoad), .cfgIn(cfgIn), .inputSignalMissing(miss), .internalReset(intRst),
    .clockOutEnable(clkEn), .alarmPinOut(pinOut), .alarmPinOe(pinOe), .alarmActive(active));
  rap_host_model u_host (.clk(clk), .alarmPinOut(pinOut), .alarmPinOe(pinOe),
    .alarmWire(pinWire));
  initial forever #20 clk = ~clk;
  // Whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string name, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic rap_pkg::rap_cfg_s cf(logic e, logic p, logic f, logic k, logic [1:0] m);
    return '{e, p, f, k, m};
  endfunction
  // Host programming, then fault level held long enough for the slow detector
  task automatic apply(rap_pkg::rap_cfg_s c, logic m);
    @(posedge clk);
    cfgLoad <= 1'h1;
    cfgIn <= c;
    miss <= {3'h0, m};
    @(posedge clk);
    cfgLoad <= 1'h0;
    cyc(6);
  endtask
  task automatic t_defaults();
    chk("intRst", 1'h0, intRst);
    chk("clkEn", 1'h0, clkEn);
    chk("oe", 1'h0, pinOe);
    chk("active", 1'h0, active);
    chk("pinOut", 1'h0, pinOut);
  endtask
  task automatic t_enable();
    apply(cf(1'h0, 1'h0, 1'h0, 1'h0, 2'h3), 1'h1);
    chk("oe", 1'h0, pinOe);
    chk("clkEn", 1'h1, clkEn);
    apply(cf(1'h1, 1'h0, 1'h0, 1'h0, 2'h3), 1'h0);
    chk("pin", 1'h0, pinWire);
    apply(cf(1'h1, 1'h0, 1'h0, 1'h0, 2'h3), 1'h1);
    chk("pin", 1'h1, pinWire);
    chk("active", 1'h1, active);
  endtask
  task automatic t_polarity();
    for (int i = 0; i < 4; i++) begin
      apply(cf(1'h1, i[0], i[1], 1'h0, 2'h3), 1'h1);
      chk("pin", 1'h1 ^ i[0] ^ i[1], pinWire);
    end
  endtask
  task automatic t_mask();
    apply(cf(1'h1, 1'h0, 1'h0, 1'h1, 2'h3), 1'h1);
    chk("active", 1'h0, active);
    chk("pin", 1'h0, pinWire);
  endtask
  task automatic t_monitor();
    for (int i = 0; i < 4; i++) begin
      apply(cf(1'h1, 1'h0, 1'h0, 1'h0, i[1:0]), 1'h1);
      chk("active", i[1], active);
    end
  endtask
  // Slow detector ignores a short loss and reports a held one later than normal
  task automatic t_slow();
    apply(cf(1'h1, 1'h0, 1'h0, 1'h0, 2'h2), 1'h0);
    chk("active", 1'h0, active);
    @(posedge clk);
    miss <= 4'h1;
    @(posedge clk);
    miss <= 4'h0;
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      chk("active", 1'h0, active);
    end
    @(posedge clk);
    miss <= 4'h1;
    cyc(SLOW + 3);
    chk("active", 1'h0, active);
    cyc(1);
    chk("active", 1'h1, active);
  endtask
  task automatic t_pin_reset();
    for (int i = 0; i < 4; i++) begin
      apply(cf(1'h1, 1'h0, 1'h0, 1'h0, 2'h3), 1'h1);
      @(posedge clk);
      pins_n[i] <= 1'h0;
      cyc(4);
      chk("intRst", 1'h1, intRst);
      chk("clkEn", 1'h0, clkEn);
      chk("oe", 1'h0, pinOe);
      chk("active", 1'h0, active);
      @(posedge clk);
      pins_n[i] <= 1'h1;
      cyc(2);
      chk("intRst", 1'h1, intRst);
      cyc(3);
      chk("intRst", 1'h0, intRst);
      chk("oe", 1'h0, pinOe);
      chk("clkEn", 1'h0, clkEn);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    cyc(3);
    t_defaults();
    t_enable();
    t_polarity();
    t_mask();
    t_monitor();
    t_slow();
    t_pin_reset();
    tally_and_finish();
  end
endmodule
